// >>> src/fdchp_fifo.sv
// the buffering fifo module sits in the host port file, which holds all design logic

// >>> src/fdchp_host_port.sv
// host processor port of the floppy controller: bus, registers, request and irq
`timescale 1ns/100ps
`default_nettype none
`include "fdchp_map.svh"

// Behaviour
// RULE1: reset loads command register with 03
// RULE2: not-ready status bit cleared during reset
// RULE3: restore command starts when reset releases
// RULE4: reset loads sector register with 01
// RULE5: chip select plus write strobe writes register
// RULE6: chip select plus read strobe drives register
// RULE7: nothing happens while chip select high
// RULE8: select code picks status/command, track, sector, data
// RULE9: bus receives on write, drives on read
// RULE10: build option inverts bus data bits
// RULE11: system supplies 2 or 1 MHz clock
// RULE12: request when byte assembled or register empty
// RULE13: request drops when host services data
// RULE14: single-density variant leaves density input open
// RULE15: irq sets on completion, clears on command/status
// RULE16: request and irq are active-high internal signals
module fdchp_host_port #(
   parameter bit INVERT_BUS = 1'b1,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic master_reset_n,
   input wire logic chip_select_n,
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   input wire logic reg_select_lo,
   input wire logic reg_select_hi,
   input wire logic [7:0] host_bus_in,
   output logic [7:0] host_bus_out,
   output logic host_bus_oe,
   output logic transfer_request,
   output logic completion_irq,
   output logic [7:0] command_word,
   output logic command_strobe,
   output logic restore_start,
   input wire fdchp_pkg::fdchp_engine_stat_type engine_status,
   input wire logic engine_done,
   input wire logic disk_byte_valid,
   output logic disk_byte_ready,
   input wire logic [7:0] disk_byte,
   output logic disk_wr_valid,
   input wire logic disk_wr_ready,
   output logic [7:0] disk_wr_byte
);
   import fdchp_pkg::*;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   // the bus arrives asynchronously; two stages before any logic looks
   logic [12:0] sync1, sync2;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sync1 <= 13'h1f00;
         sync2 <= 13'h1f00;
      end else begin
         sync1 <= {master_reset_n, chip_select_n, host_read_strobe_n, host_write_strobe_n,
                   reg_select_lo, host_bus_in};
         sync2 <= sync1;
      end
   end

   fdchp_bus_ctl_type ctl;
   logic mr_n;
   logic [7:0] bus_val;
   logic sel_hi_1, sel_hi_s;
   assign mr_n = sync2[12];
   assign ctl.cs_n = sync2[11];
   assign ctl.rd_n = sync2[10];
   assign ctl.wr_n = sync2[9];
   assign ctl.sel = {sel_hi_s, sync2[8]};
   // inverted variants complement every bit on the bus
   assign bus_val = INVERT_BUS ? ~sync2[7:0] : sync2[7:0]; // [RULE10]

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sel_hi_1 <= 1'b0;
         sel_hi_s <= 1'b0;
      end else begin
         sel_hi_1 <= reg_select_hi;
         sel_hi_s <= sel_hi_1;
      end
   end

   // ------------------------------------------------------------
   // strobe decode
   // ------------------------------------------------------------
   // act once per strobe, on its falling edge after synchronising
   logic rd_act, wr_act, rd_act_q, wr_act_q, rd_evt, wr_evt;
   assign rd_act = !ctl.cs_n && !ctl.rd_n; // [RULE6] [RULE7]
   assign wr_act = !ctl.cs_n && !ctl.wr_n; // [RULE5] [RULE7]
   assign rd_evt = rd_act && !rd_act_q;
   assign wr_evt = wr_act && !wr_act_q;

   // ------------------------------------------------------------
   // data path buffering
   // ------------------------------------------------------------
   logic wfifo_ready, rfifo_valid, rfifo_pop;
   logic [7:0] rfifo_data;
   logic wfifo_push;
   logic [7:0] data_holding_reg, next_data_holding_reg;

   fdchp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_read_fifo (
      .mclk(mclk),
      .nrst(nrst),
      .in_valid(disk_byte_valid),
      .in_ready(disk_byte_ready),
      .in_data(disk_byte),
      .out_valid(rfifo_valid),
      .out_ready(rfifo_pop),
      .out_data(rfifo_data)
   );

   fdchp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_write_fifo (
      .mclk(mclk),
      .nrst(nrst),
      .in_valid(wfifo_push),
      .in_ready(wfifo_ready),
      .in_data(data_holding_reg),
      .out_valid(disk_wr_valid),
      .out_ready(disk_wr_ready),
      .out_data(disk_wr_byte)
   );

   // ------------------------------------------------------------
   // registers and transfer state
   // ------------------------------------------------------------
   logic [7:0] track_number, next_track_number;
   logic [7:0] sector_number, next_sector_number;
   logic [7:0] next_command_word;
   logic data_full, next_data_full;
   logic next_command_strobe, next_restore_start, next_irq;
   logic in_reset, next_in_reset;
   fdchp_xfer_type xfer, next_xfer;
   logic data_sel;

   assign data_sel = (ctl.sel == `FDCHP_SEL_DATA);
   assign rfifo_pop = (xfer == FDCHP_READING) && !data_full && rfifo_valid;
   // a full write fifo stalls the host: the byte stays until there is room
   assign wfifo_push = (xfer == FDCHP_WRITING) && data_full && wfifo_ready;

   always_comb begin
      next_track_number = track_number;
      next_sector_number = sector_number;
      next_data_holding_reg = data_holding_reg;
      next_command_word = command_word;
      next_data_full = data_full;
      next_command_strobe = 1'b0;
      next_restore_start = 1'b0;
      next_irq = completion_irq;
      next_xfer = xfer;
      next_in_reset = !mr_n;
      if (!mr_n) begin
         next_command_word = `FDCHP_CMD_RESET; // [RULE1]
         next_sector_number = `FDCHP_SECTOR_RESET; // [RULE4]
         next_data_full = 1'b0;
         next_irq = 1'b0;
         next_xfer = FDCHP_IDLE;
      end else begin
         if (in_reset) begin
            // restore runs whatever the drive's ready line says
            next_restore_start = 1'b1; // [RULE3]
            next_command_strobe = 1'b1; // [RULE3]
         end
         if (rfifo_pop) begin
            next_data_holding_reg = rfifo_data;
            next_data_full = 1'b1;
         end
         if (wfifo_push) begin
            next_data_full = 1'b0;
         end
         if (engine_done) begin
            next_irq = 1'b1; // [RULE15]
            next_xfer = FDCHP_IDLE;
         end
         if (wr_evt) begin // [RULE9]
            unique case (ctl.sel) // [RULE8]
               `FDCHP_SEL_STATUS: begin
                  next_command_word = bus_val;
                  next_command_strobe = 1'b1;
                  next_irq = 1'b0; // [RULE15]
                  next_data_full = 1'b0;
                  if (bus_val[7:5] == `FDCHP_READ_CMD_TOP) begin
                     next_xfer = FDCHP_READING;
                  end else if (bus_val[7:5] == `FDCHP_WRITE_CMD_TOP) begin
                     next_xfer = FDCHP_WRITING;
                  end else begin
                     next_xfer = FDCHP_IDLE;
                  end
               end
               `FDCHP_SEL_TRACK: next_track_number = bus_val;
               `FDCHP_SEL_SECTOR: next_sector_number = bus_val;
               `FDCHP_SEL_DATA: begin
                  next_data_holding_reg = bus_val;
                  // a loaded byte clears the request in write operations
                  if (xfer == FDCHP_WRITING) begin
                     next_data_full = 1'b1; // [RULE13]
                  end
               end
            endcase
         end
         if (rd_evt) begin
            if (ctl.sel == `FDCHP_SEL_STATUS) begin
               next_irq = 1'b0; // [RULE15]
            end else if (data_sel && xfer == FDCHP_READING && data_full) begin
               next_data_full = 1'b0; // [RULE13]
            end
         end
         // engine completion wins over a clear in the same cycle
         if (engine_done) begin
            next_irq = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         track_number <= `FDCHP_TRACK_RESET;
         sector_number <= `FDCHP_SECTOR_RESET;
         data_holding_reg <= `FDCHP_DATA_RESET;
         command_word <= `FDCHP_CMD_RESET;
         data_full <= 1'b0;
         command_strobe <= 1'b0;
         restore_start <= 1'b0;
         completion_irq <= 1'b0;
         xfer <= FDCHP_IDLE;
         in_reset <= 1'b1;
         rd_act_q <= 1'b0;
         wr_act_q <= 1'b0;
      end else begin
         track_number <= next_track_number;
         sector_number <= next_sector_number;
         data_holding_reg <= next_data_holding_reg;
         command_word <= next_command_word;
         data_full <= next_data_full;
         command_strobe <= next_command_strobe;
         restore_start <= next_restore_start;
         completion_irq <= next_irq; // [RULE16]
         xfer <= next_xfer;
         in_reset <= next_in_reset;
         rd_act_q <= rd_act;
         wr_act_q <= wr_act;
      end
   end

   // ------------------------------------------------------------
   // request and read-back
   // ------------------------------------------------------------
   always_comb begin
      unique case (xfer)
         FDCHP_READING: transfer_request = data_full; // [RULE12] [RULE16]
         FDCHP_WRITING: transfer_request = !data_full; // [RULE12]
         default: transfer_request = 1'b0;
      endcase
   end

   logic [7:0] status_word, read_val, next_bus_out;
   always_comb begin
      status_word = {engine_status.not_ready, engine_status.engine_bits, engine_status.busy};
      status_word[`FDCHP_DRQ_BIT] = transfer_request;
      if (!mr_n) begin
         status_word[`FDCHP_NOT_READY_BIT] = 1'b0; // [RULE2]
      end
      unique case (ctl.sel) // [RULE8]
         `FDCHP_SEL_STATUS: read_val = status_word;
         `FDCHP_SEL_TRACK: read_val = track_number;
         `FDCHP_SEL_SECTOR: read_val = sector_number;
         `FDCHP_SEL_DATA: read_val = data_holding_reg;
      endcase
      // hold the byte for the whole strobe so a refill cannot change it mid-read
      next_bus_out = host_bus_out;
      if (rd_evt) begin
         next_bus_out = INVERT_BUS ? ~read_val : read_val; // [RULE10]
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         host_bus_out <= 8'h00;
         host_bus_oe <= 1'b0;
      end else begin
         host_bus_out <= next_bus_out; // [RULE6]
         host_bus_oe <= rd_act; // [RULE9] [RULE7]
      end
   end

endmodule : fdchp_host_port

// ------------------------------------------------------------
// buffering fifo
// ------------------------------------------------------------
module fdchp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // storage holds no reset so it maps to plain flip-flops without clear
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

endmodule : fdchp_fifo

`default_nettype wire

// >>> src/fdchp_map.svh
// register map, reset values, status bit positions and command codes of the floppy host port
`ifndef FDCHP_MAP_SVH
`define FDCHP_MAP_SVH

`define FDCHP_SEL_STATUS 2'h0
`define FDCHP_SEL_TRACK 2'h1
`define FDCHP_SEL_SECTOR 2'h2
`define FDCHP_SEL_DATA 2'h3
`define FDCHP_CMD_RESET 8'h03
`define FDCHP_SECTOR_RESET 8'h01
`define FDCHP_TRACK_RESET 8'h00
`define FDCHP_DATA_RESET 8'h00
`define FDCHP_NOT_READY_BIT 7
`define FDCHP_BUSY_BIT 0
`define FDCHP_DRQ_BIT 1
`define FDCHP_CMD_TYPE_HI 7
`define FDCHP_READ_CMD_TOP 3'h4
`define FDCHP_WRITE_CMD_TOP 3'h5
`define FDCHP_FORCE_IRQ_TOP 4'hd

`endif

// >>> src/fdchp_pkg.sv
// types shared by the floppy host port
package fdchp_pkg;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic [1:0] sel;
   } fdchp_bus_ctl_type;

   typedef struct packed {
      logic busy;
      logic not_ready;
      logic [5:0] engine_bits;
   } fdchp_engine_stat_type;

   typedef enum logic [1:0] {
      FDCHP_IDLE,
      FDCHP_READING,
      FDCHP_WRITING
   } fdchp_xfer_type;

endpackage : fdchp_pkg

// >>> test/fdchp_host_model.sv
// host processor model driving the parallel register bus
`timescale 1ns/100ps
`default_nettype none
module fdchp_host_model #(
   parameter bit INV = 1'b1
) (
   input wire logic mclk,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [1:0] sel,
   output logic [7:0] bus,
   input wire logic [7:0] bus_out,
   input wire logic bus_oe
);
   logic drv = 1'b0;
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      sel = 2'h0;
      bus = 8'h5a;
   end
   // a released bus must not keep showing the last byte written
   always @(negedge mclk) begin
      if (!drv) begin
         bus <= ~bus;
      end
   end
   // strobe low 5 cycles, high 4: the device syncs every pin through 2 ff
   task automatic xfer(input logic en, input logic wr, input logic [1:0] s,
                       input logic [7:0] d, output logic [7:0] q, output logic oe);
      @(posedge mclk);
      drv = wr;
      cs_n <= !en;
      rd_n <= wr;
      wr_n <= !wr;
      sel <= s;
      bus <= wr ? (INV ? ~d : d) : bus;
      repeat (5) @(posedge mclk);
      q = INV ? ~bus_out : bus_out;
      oe = bus_oe;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      drv = 1'b0;
      repeat (4) @(posedge mclk);
   endtask : xfer
endmodule : fdchp_host_model
`default_nettype wire

// >>> test/fdchp_host_port_monitor.sv
// concurrent checks on the floppy host port pins
`timescale 1ns/100ps
`default_nettype none
module fdchp_host_port_monitor (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic master_reset_n,
   input wire logic chip_select_n,
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   input wire logic host_bus_oe,
   input wire logic transfer_request,
   input wire logic completion_irq,
   input wire logic [7:0] command_word,
   input wire logic command_strobe,
   input wire logic restore_start,
   input wire logic engine_done
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   // five cycles cover the 2-ff input sync plus the register stage
   sequence s_mr_held;
      !master_reset_n [*5];
   endsequence
   sequence s_mr_release;
      s_mr_held ##1 master_reset_n;
   endsequence
   a_idle_no_drive: assert property (chip_select_n [*5] |-> !host_bus_oe)
      else $error("bus driven while deselected");
   a_drive_needs_read: assert property (host_read_strobe_n [*5] |-> !host_bus_oe)
      else $error("bus driven without read strobe");
   a_reset_cmd_value: assert property (s_mr_held |-> command_word == 8'h03)
      else $error("command not 03 in master reset");
   a_reset_irq_low: assert property (s_mr_held |-> !completion_irq)
      else $error("irq high in master reset");
   a_reset_no_request: assert property (s_mr_held |-> !transfer_request)
      else $error("request high in master reset");
   a_restore_after_mr: assert property (s_mr_release |-> ##[1:5] restore_start)
      else $error("no restore after master reset");
   a_restore_one_cycle: assert property (restore_start |-> command_strobe ##1 !restore_start)
      else $error("restore pulse malformed");
   a_done_sets_irq: assert property (engine_done |=> completion_irq)
      else $error("irq not set on completion");
   a_idle_cmd_stable: assert property ((chip_select_n && master_reset_n) [*5] |-> $stable(command_word))
      else $error("command changed while deselected");
   a_nowrite_stable: assert property ((host_write_strobe_n && master_reset_n) [*5] |-> $stable(command_word))
      else $error("command changed without write strobe");
endmodule : fdchp_host_port_monitor
bind fdchp_host_port fdchp_host_port_monitor u_fdchp_host_port_monitor (.*);
`default_nettype wire

// >>> test/fdchp_host_port_tb.sv
// self-checking bench of the floppy host port
`timescale 1ns/100ps
`default_nettype none
module fdchp_host_port_tb;
   import fdchp_pkg::*;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic master_reset_n = 1'b1;
   logic chip_select_n, host_read_strobe_n, host_write_strobe_n;
   logic [1:0] sel;
   logic [7:0] host_bus_in, host_bus_out, command_word, disk_wr_byte;
   logic host_bus_oe, transfer_request, completion_irq, command_strobe, restore_start;
   fdchp_engine_stat_type engine_status = 8'h40;
   logic engine_done = 1'b0;
   logic disk_byte_valid = 1'b0;
   logic disk_byte_ready, disk_wr_valid;
   logic disk_wr_ready = 1'b0;
   logic [7:0] disk_byte = 8'h00;
   logic [7:0] q;
   logic oe;
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;
   int n_cmd = 0;
   // the port has no density input, so single density needs nothing here
   fdchp_host_port u_fdchp_host_port (.mclk, .nrst, .master_reset_n, .chip_select_n,
      .host_read_strobe_n, .host_write_strobe_n, .reg_select_lo(sel[0]),
      .reg_select_hi(sel[1]), .host_bus_in, .host_bus_out, .host_bus_oe, .transfer_request,
      .completion_irq, .command_word, .command_strobe, .restore_start, .engine_status,
      .engine_done, .disk_byte_valid, .disk_byte_ready, .disk_byte, .disk_wr_valid,
      .disk_wr_ready, .disk_wr_byte);
   fdchp_host_model u_fdchp_host_model (.mclk, .cs_n(chip_select_n),
      .rd_n(host_read_strobe_n), .wr_n(host_write_strobe_n), .sel, .bus(host_bus_in),
      .bus_out(host_bus_out), .bus_oe(host_bus_oe));
   initial begin
      forever #10 mclk = ~mclk; // free-running reference at the block clock
   end
   task automatic give_verdict;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic acc(input logic en, input logic wr, input logic [1:0] s, input logic [7:0] d);
      u_fdchp_host_model.xfer(en, wr, s, d, q, oe);
   endtask : acc
   task automatic pulse_done;
      @(posedge mclk);
      engine_done <= 1'b1;
      @(posedge mclk);
      engine_done <= 1'b0;
      @(posedge mclk);
   endtask : pulse_done
   task automatic t_reset;
      check(command_word, 8'h03);
      acc(1'b1, 1'b0, 2'h2, 8'h00);
      check(q, 8'h01);
      acc(1'b1, 1'b0, 2'h0, 8'h00);
      check(q, 8'h80);
      check({7'h00, oe}, 8'h01);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_regs;
      int s;
      for (int i = 0; i < 2; i++) begin
         acc(1'b1, 1'b1, 2'h1, i ? 8'ha5 : 8'h3c);
         acc(1'b1, 1'b1, 2'h2, i ? 8'h5a : 8'hc3);
         acc(1'b1, 1'b0, 2'h1, 8'h00);
         check(q, i ? 8'ha5 : 8'h3c);
         acc(1'b1, 1'b0, 2'h2, 8'h00);
         check(q, i ? 8'h5a : 8'hc3);
      end
      acc(1'b0, 1'b1, 2'h1, 8'h77);
      acc(1'b0, 1'b0, 2'h1, 8'h00);
      check({7'h00, oe}, 8'h00);
      acc(1'b1, 1'b0, 2'h1, 8'h00);
      check(q, 8'ha5);
      s = n_cmd;
      acc(1'b1, 1'b1, 2'h0, 8'h0b);
      check(command_word, 8'h0b);
      check(8'(n_cmd - s), 8'h01);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_mr;
      logic hit;
      @(posedge mclk);
      master_reset_n <= 1'b0;
      repeat (8) @(posedge mclk);
      acc(1'b1, 1'b0, 2'h0, 8'h00);
      check(q & 8'h80, 8'h00);
      check(command_word, 8'h03);
      master_reset_n <= 1'b1;
      hit = 1'b0;
      repeat (8) begin
         @(posedge mclk);
         hit |= restore_start;
      end
      check({7'h00, hit}, 8'h01);
      acc(1'b1, 1'b0, 2'h2, 8'h00);
      check(q, 8'h01);
      $display("t_mr done");
   endtask : t_mr
   task automatic t_read_op;
      logic [7:0] n;
      acc(1'b1, 1'b1, 2'h0, 8'h80);
      disk_byte_valid <= 1'b1;
      disk_byte <= 8'h10;
      n = 8'h00;
      repeat (40) begin
         @(posedge mclk);
         if (disk_byte_ready === 1'b1) begin
            n++;
            disk_byte <= 8'h10 + n;
         end
      end
      disk_byte_valid <= 1'b0;
      check(n, 8'h09);
      check({7'h00, transfer_request}, 8'h01);
      for (int i = 0; i < 9; i++) begin
         acc(1'b1, 1'b0, 2'h3, 8'h00);
         check(q, 8'h10 + 8'(i));
      end
      check({7'h00, transfer_request}, 8'h00);
      pulse_done();
      check({7'h00, completion_irq}, 8'h01);
      acc(1'b1, 1'b0, 2'h0, 8'h00);
      check({7'h00, completion_irq}, 8'h00);
      $display("t_read_op done");
   endtask : t_read_op
   task automatic t_write_op;
      logic [7:0] n;
      pulse_done();
      acc(1'b1, 1'b1, 2'h0, 8'ha0);
      check({7'h00, completion_irq}, 8'h00);
      check({7'h00, transfer_request}, 8'h01);
      for (int i = 0; i < 9; i++) begin
         acc(1'b1, 1'b1, 2'h3, 8'h40 + 8'(i));
      end
      check({7'h00, transfer_request}, 8'h00);
      disk_wr_ready <= 1'b1;
      n = 8'h00;
      repeat (40) begin
         @(posedge mclk);
         if (disk_wr_valid === 1'b1) begin
            check(disk_wr_byte, 8'h40 + n);
            n++;
         end
      end
      check(n, 8'h09);
      check({7'h00, transfer_request}, 8'h01);
      $display("t_write_op done");
   endtask : t_write_op
   // a hang ends the run as a failure
   always @(posedge mclk) begin
      cycles++;
      if (command_strobe === 1'b1) begin
         n_cmd++;
      end
      if (cycles == 5000) begin
         failures++;
         give_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      repeat (2) @(posedge mclk);
      t_reset();
      t_regs();
      t_mr();
      t_read_op();
      t_write_op();
      give_verdict();
   end
endmodule : fdchp_host_port_tb
`default_nettype wire
